// *** shared/gpio_ports_defines.vh ***
// Register offsets, field positions and masks for ports B, C and D
`ifndef GPIO_PORTS_DEFINES_VH
`define GPIO_PORTS_DEFINES_VH

// ==========================================================
// Register offsets
`define OFS_SER_DATA     4'h1
`define OFS_ANA_DATA     4'h2
`define OFS_CAP_DATA     4'h3
`define OFS_SER_DIR      4'h5
`define OFS_ANA_DIR      4'h6
`define OFS_CAP_DIR      4'h7
`define OFS_PERIPH_CTRL  4'h8

// ==========================================================
// Implemented bit masks
`define SER_MASK         8'hE0
`define ANA_MASK         8'hFF
`define CAP_DATA_MASK    8'hA0
`define CAP_DIR_MASK     8'h20
`define CAP_FIXED_ONE    8'h10
`define ANA_OUT_ON_MASK  8'h07
`define ANA_SHARED_MASK  8'hF8
`define DIR_RESET        8'h00

// ==========================================================
// Field positions
`define SER_CLK_BIT      7
`define SER_IN_BIT       6
`define SER_OUT_BIT      5
`define CAP_IN_BIT       7
`define CAP_BIDIR_BIT    5
`define CTRL_SER_EN      0
`define CTRL_SER_MASTER  1
`define CTRL_ADC_ON      2
`define CTRL_CHAN_LO     4
`define CTRL_CHAN_HI     5

`endif

// *** src/pin_sync.v ***
// Two-flop synchroniser for a bank of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         ref_clk,
    input  wire         arst_n,
    // Data
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule
`default_nettype wire

// *** src/port_bit_mux.v ***
// Per-bit read selection between data latch and pin level
`timescale 1ns/1ps
`default_nettype none
module port_bit_mux (
    // Selection
    input  wire [7:0] dir_bits,
    input  wire [7:0] impl_mask,
    // Sources
    input  wire [7:0] latch_bits,
    input  wire [7:0] pin_bits,
    // Result
    output wire [7:0] read_bits
);
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign read_bits[i] = impl_mask[i] &
                (dir_bits[i] ? latch_bits[i] : pin_bits[i]);
        end
    endgenerate
endmodule
`default_nettype wire

// *** src/parallel_ports_b_c_d.v ***
// Parallel ports B, C and D with serial, converter and capture sharing
`timescale 1ns/1ps
`default_nettype none
`include "gpio_ports_defines.vh"

// How it works
// - Three-pin port doubles as serial clock, data-in, data-out when enabled.
// - Serial port data bits 7..5 read/write; reset leaves them unchanged.
// - Serial owns direction of its pins; direction bits still pick read source.
// - Serial clock pin drives in master mode, is input in slave mode.
// - One shared pin is serial data in, another serial data out.
// - Serial use leaves latch and direction intact; software need not reinitialise.
// - Reset clears serial port direction bits; 1 means output.
// - Direction one enables pin driver; zero leaves pin undriven.
// - Data writes always update latch, never the observed input.
// - Eight-pin port; five converter pins are plain I/O when converter off.
// - Eight-pin port data bits read/write; reset leaves them unchanged.
// - Converter on: bit 7 reference, bits 6..3 analog; only 2..0 drive.
// - Converter on: bit of the selected analog channel reads zero.
// - Eight-pin direction resets to zero; 1 means output.
// - Two-pin port: one bidirectional pin, one input-only capture pin.
// - Two-pin port direction bit 5 controls bidir pin; reset clears it.
// - Two-pin port data bits 7 and 5 read/write; reset leaves them.
module parallel_ports_b_c_d (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       arst_n,
    // Register port
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Serial-shared pins, bits 7..5
    input  wire [2:0] ser_pin_in,
    output wire [2:0] ser_pin_out,
    output wire [2:0] ser_pin_oe_n,
    // Analog-shared pins
    input  wire [7:0] ana_pin_in,
    output wire [7:0] ana_pin_out,
    output wire [7:0] ana_pin_oe_n,
    // Capture-shared pins: bidir bit and input-only bit
    input  wire       bidir_pin_in,
    output wire       bidir_pin_out,
    output wire       bidir_pin_oe_n,
    input  wire       timer_capture_pin,
    // Synchronous serial port side
    input  wire       ser_clk_out,
    input  wire       ser_data_out,
    output wire       ser_clk_in,
    output wire       ser_data_in,
    // Converter and timer side
    output wire       adc_on,
    output wire [1:0] adc_channel,
    output wire       capture_in
);
    // ======================================================
    // Storage
    reg  [7:0] ser_data_ff;
    reg  [7:0] ser_dir_ff;
    reg  [7:0] ana_data_ff;
    reg  [7:0] ana_dir_ff;
    reg  [7:0] cap_data_ff;
    reg  [7:0] cap_dir_ff;
    reg  [7:0] ctrl_ff;
    reg  [7:0] nxt_rdata;

    wire [7:0] ser_pins_s;
    wire [7:0] ana_pins_s;
    wire [1:0] cap_pins_s;
    wire [7:0] ser_rd;
    wire [7:0] ana_rd;
    wire [7:0] cap_rd;

    wire       ser_en     = ctrl_ff[`CTRL_SER_EN];
    wire       ser_master = ctrl_ff[`CTRL_SER_MASTER];
    wire       conv_on    = ctrl_ff[`CTRL_ADC_ON];
    wire [1:0] chan       = ctrl_ff[`CTRL_CHAN_HI:`CTRL_CHAN_LO];

    function sel;
        input [3:0] a;
        input [3:0] ofs;
        begin
            sel = (a == ofs);
        end
    endfunction

    // ======================================================
    // Pin synchronisers
    pin_sync #(.W(8)) u_sync_ser (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .async_in ({ser_pin_in, 5'h00}),
        .sync_out (ser_pins_s)
    );

    pin_sync #(.W(8)) u_sync_ana (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .async_in (ana_pin_in),
        .sync_out (ana_pins_s)
    );

    pin_sync #(.W(2)) u_sync_cap (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .async_in ({timer_capture_pin, bidir_pin_in}),
        .sync_out (cap_pins_s)
    );

    // ======================================================
    // Data latches: no reset, writes always land
    always @(posedge ref_clk) begin
        if (reg_wr && sel(reg_addr, `OFS_SER_DATA))
            ser_data_ff <= reg_wdata & `SER_MASK;
        if (reg_wr && sel(reg_addr, `OFS_ANA_DATA))
            ana_data_ff <= reg_wdata & `ANA_MASK;
        if (reg_wr && sel(reg_addr, `OFS_CAP_DATA))
            cap_data_ff <= reg_wdata & `CAP_DATA_MASK;
    end

    // ======================================================
    // Direction and control registers
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ser_dir_ff <= `DIR_RESET;
            ana_dir_ff <= `DIR_RESET;
            cap_dir_ff <= `DIR_RESET;
            ctrl_ff    <= 8'h00;
        end else if (reg_wr) begin
            if (sel(reg_addr, `OFS_SER_DIR))
                ser_dir_ff <= reg_wdata & `SER_MASK;
            if (sel(reg_addr, `OFS_ANA_DIR))
                ana_dir_ff <= reg_wdata & `ANA_MASK;
            if (sel(reg_addr, `OFS_CAP_DIR))
                cap_dir_ff <= reg_wdata & `CAP_DIR_MASK;
            if (sel(reg_addr, `OFS_PERIPH_CTRL))
                ctrl_ff <= reg_wdata & 8'h37;
        end
    end

    // ======================================================
    // Serial-shared port drivers
    // Serial port takes direction of its pins; latches stay intact,
    // so software must reinitialise only by its own choice.
    wire ser_clk_drv = ser_en ? ser_master
                              : ser_dir_ff[`SER_CLK_BIT];
    wire ser_in_drv  = ser_en ? 1'b0
                              : ser_dir_ff[`SER_IN_BIT];
    wire ser_out_drv = ser_en ? 1'b1
                              : ser_dir_ff[`SER_OUT_BIT];

    assign ser_pin_out[2] = ser_en ? ser_clk_out
                                   : ser_data_ff[`SER_CLK_BIT];
    assign ser_pin_out[1] = ser_data_ff[`SER_IN_BIT];
    assign ser_pin_out[0] = ser_en ? ser_data_out
                                   : ser_data_ff[`SER_OUT_BIT];
    assign ser_pin_oe_n   = ~{ser_clk_drv, ser_in_drv, ser_out_drv};

    // Slave clock and data-in come from the synchronised pins
    assign ser_clk_in  = ser_pins_s[`SER_CLK_BIT];
    assign ser_data_in = ser_pins_s[`SER_IN_BIT];

    // ======================================================
    // Analog-shared port drivers
    // Converter on: only the low three pins may drive
    wire [7:0] ana_drv = conv_on ? (ana_dir_ff & `ANA_OUT_ON_MASK)
                                 : ana_dir_ff;
    assign ana_pin_out  = ana_data_ff;
    assign ana_pin_oe_n = ~ana_drv;
    assign adc_on       = conv_on;
    assign adc_channel  = chan;

    // ======================================================
    // Capture-shared port drivers
    assign bidir_pin_out  = cap_data_ff[`CAP_BIDIR_BIT];
    assign bidir_pin_oe_n = ~cap_dir_ff[`CAP_BIDIR_BIT];
    assign capture_in     = cap_pins_s[1];

    // ======================================================
    // Read paths
    port_bit_mux u_mux_ser (
        .dir_bits   (ser_dir_ff),
        .impl_mask  (`SER_MASK),
        .latch_bits (ser_data_ff),
        .pin_bits   (ser_pins_s),
        .read_bits  (ser_rd)
    );

    port_bit_mux u_mux_ana (
        .dir_bits   (ana_dir_ff),
        .impl_mask  (`ANA_MASK),
        .latch_bits (ana_data_ff),
        .pin_bits   (ana_pins_s),
        .read_bits  (ana_rd)
    );

    // Input-only bit has no direction bit; it always reads the pin
    port_bit_mux u_mux_cap (
        .dir_bits   (cap_dir_ff),
        .impl_mask  (`CAP_DATA_MASK),
        .latch_bits (cap_data_ff),
        .pin_bits   ({cap_pins_s[1], 1'b0, cap_pins_s[0], 5'h00}),
        .read_bits  (cap_rd)
    );

    // Channel 0..3 sits on pin 6..3
    wire [7:0] chan_hole = conv_on ? (8'h40 >> chan) : 8'h00;

    always @* begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `OFS_SER_DATA:    nxt_rdata = ser_rd;
                `OFS_ANA_DATA:    nxt_rdata = ana_rd & ~chan_hole;
                `OFS_CAP_DATA:    nxt_rdata = cap_rd | `CAP_FIXED_ONE;
                `OFS_SER_DIR:     nxt_rdata = ser_dir_ff;
                `OFS_ANA_DIR:     nxt_rdata = ana_dir_ff;
                `OFS_CAP_DIR:     nxt_rdata = cap_dir_ff;
                `OFS_PERIPH_CTRL: nxt_rdata = ctrl_ff;
                default:          nxt_rdata = 8'h00;
            endcase
        end
    end

    // Read data valid the cycle after the strobe, zero otherwise
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= nxt_rdata;
    end
endmodule
`default_nettype wire

// *** sim/pin_board_model.sv ***
// Board model resolving each port pin from device drive and board level
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
    // Device drive
    input  wire logic [2:0] ser_pin_out,
    input  wire logic [2:0] ser_pin_oe_n,
    input  wire logic [7:0] ana_pin_out,
    input  wire logic [7:0] ana_pin_oe_n,
    input  wire logic       bidir_pin_out,
    input  wire logic       bidir_pin_oe_n,
    // Board levels where the device is off the pin
    input  wire logic [2:0] ser_ext,
    input  wire logic [7:0] ana_ext,
    input  wire logic       bidir_ext,
    // Resolved levels
    output wire logic [2:0] ser_pin_in,
    output wire logic [7:0] ana_pin_in,
    output wire logic       bidir_pin_in
);
    // ==========================================================
    // Board only wins on undriven pins, so no contention is modelled
    assign ser_pin_in = (ser_pin_out & ~ser_pin_oe_n) | (ser_ext & ser_pin_oe_n);
    assign ana_pin_in = (ana_pin_out & ~ana_pin_oe_n) | (ana_ext & ana_pin_oe_n);
    assign bidir_pin_in = bidir_pin_oe_n ? bidir_ext : bidir_pin_out;
endmodule
`default_nettype wire

// *** sim/parallel_ports_asserts.sv ***
// Checker for register reads and pin drive of the port block
`timescale 1ns/1ps
`default_nettype none
module parallel_ports_asserts (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       arst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and side outputs
    input wire logic [2:0] ser_pin_out,
    input wire logic [2:0] ser_pin_oe_n,
    input wire logic [7:0] ana_pin_oe_n,
    input wire logic       bidir_pin_oe_n,
    input wire logic       ser_data_out,
    input wire logic       ser_clk_out,
    input wire logic       adc_on,
    input wire logic [1:0] adc_channel
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Serial mode mirror, the control bits are not on any port
    logic ser_en_ff;
    logic master_ff;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ser_en_ff <= 1'b0;
            master_ff <= 1'b0;
        end else if (reg_wr && reg_addr == 4'h8) begin
            ser_en_ff <= reg_wdata[0];
            master_ff <= reg_wdata[1];
        end
    end
    // ==========================================================
    // Properties
    a_unmapped_read_zero: assert property ($past(reg_rd) && ($past(reg_addr) == 4'h0
        || $past(reg_addr) == 4'h4 || $past(reg_addr) > 4'h8) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ser_read_holes: assert property ($past(reg_rd) && ($past(reg_addr) == 4'h1
        || $past(reg_addr) == 4'h5) |-> reg_rdata[4:0] == 5'h00)
        else $error("serial port hole bits not zero");
    a_cap_read_fixed: assert property ($past(reg_rd) && $past(reg_addr) == 4'h3
        |-> (reg_rdata & 8'h5F) == 8'h10) else $error("capture data fixed bits wrong");
    a_ana_dir_drive: assert property ($past(reg_wr) && $past(reg_addr) == 4'h6
        && !adc_on |-> ana_pin_oe_n == ~$past(reg_wdata))
        else $error("analog pin enables do not follow direction");
    a_adc_pins_off: assert property (adc_on |-> ana_pin_oe_n[7:3] == 5'h1F)
        else $error("analog pin driven while converter on");
    a_bidir_dir_drive: assert property ($past(reg_wr) && $past(reg_addr) == 4'h7
        |-> bidir_pin_oe_n != $past(reg_wdata[5])) else $error("bidir enable wrong");
    a_ser_dir_drive: assert property ($past(reg_wr) && $past(reg_addr) == 4'h5
        && !ser_en_ff |-> ser_pin_oe_n == ~$past(reg_wdata[7:5]))
        else $error("serial pin enables do not follow direction");
    a_ser_data_pins: assert property (ser_en_ff |-> ser_pin_oe_n[1:0] == 2'h2
        && ser_pin_out[0] == ser_data_out) else $error("serial data pins wrong");
    a_ser_clk_pin: assert property (ser_en_ff |-> ser_pin_oe_n[2] == !master_ff
        && (!master_ff || ser_pin_out[2] == ser_clk_out))
        else $error("serial clock pin wrong");
    a_ctrl_outputs: assert property ($past(reg_wr) && $past(reg_addr) == 4'h8
        |-> adc_on == $past(reg_wdata[2]) && adc_channel == $past(reg_wdata[5:4]))
        else $error("converter controls do not follow write");
endmodule
bind parallel_ports_b_c_d parallel_ports_asserts i_parallel_ports_asserts (
    .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ser_pin_out, .ser_pin_oe_n, .ana_pin_oe_n, .bidir_pin_oe_n,
    .ser_data_out, .ser_clk_out, .adc_on, .adc_channel);
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for ports B, C and D
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       ref_clk, arst_n, reg_wr, reg_rd, bidir_ext;
    logic       timer_capture_pin, ser_clk_out, ser_data_out;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, ana_ext;
    logic [2:0] ser_ext;
    wire  [7:0] reg_rdata, ana_pin_in, ana_pin_out, ana_pin_oe_n;
    wire  [2:0] ser_pin_in, ser_pin_out, ser_pin_oe_n;
    wire        bidir_pin_in, bidir_pin_out, bidir_pin_oe_n, capture_in;
    wire        ser_clk_in, ser_data_in, adc_on;
    wire  [1:0] adc_channel;
    int         n_errors = 0;
    int         n_compared = 0;
    parallel_ports_b_c_d i_parallel_ports_b_c_d (.ref_clk, .arst_n,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ser_pin_in,
        .ser_pin_out, .ser_pin_oe_n, .ana_pin_in, .ana_pin_out, .ana_pin_oe_n,
        .bidir_pin_in, .bidir_pin_out, .bidir_pin_oe_n, .timer_capture_pin,
        .ser_clk_out, .ser_data_out, .ser_clk_in, .ser_data_in, .adc_on,
        .adc_channel, .capture_in);
    pin_board_model i_pin_board_model (.ser_pin_out, .ser_pin_oe_n,
        .ana_pin_out, .ana_pin_oe_n, .bidir_pin_out, .bidir_pin_oe_n, .ser_ext,
        .ana_ext, .bidir_ext, .ser_pin_in, .ana_pin_in, .bidir_pin_in);
    // ==========================================================
    // Tasks
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // Let the write land before anyone looks at the pins
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask
    // Two sync flops plus margin before a pin change is readable
    task automatic settle;
        repeat (3) @(posedge ref_clk);
    endtask
    // ==========================================================
    // Clock, watchdog, tests
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #50000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {ser_ext, bidir_ext, timer_capture_pin} = '0;
        {ser_clk_out, ser_data_out} = 2'h3;
        ana_ext = 8'hA5;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(4'h5, 8'h00);
        rd(4'h6, 8'h00);
        rd(4'h7, 8'h00);
        check(ana_pin_oe_n, 8'hFF);
        rd(4'h2, 8'hA5);
        wr(4'h2, 8'h3C);
        rd(4'h2, 8'hA5);
        wr(4'h6, 8'hF0);
        rd(4'h2, 8'h35);
        check(ana_pin_oe_n, 8'h0F);
        check(ana_pin_out, 8'h3C);
        wr(4'h1, 8'hFF);
        wr(4'h5, 8'hFF);
        rd(4'h5, 8'hE0);
        rd(4'h1, 8'hE0);
        wr(4'h5, 8'h00);
        ser_ext <= 3'h2;
        settle;
        rd(4'h1, 8'h40);
        wr(4'h7, 8'hFF);
        rd(4'h7, 8'h20);
        wr(4'h3, 8'hFF);
        rd(4'h3, 8'h30);
        check({6'h00, bidir_pin_out, bidir_pin_oe_n}, 8'h02);
        timer_capture_pin <= 1'b1;
        settle;
        rd(4'h3, 8'hB0);
        check({7'h00, capture_in}, 8'h01);
        rd(4'h0, 8'h00);
        rd(4'h4, 8'h00);
        rd(4'hF, 8'h00);
        wr(4'h8, 8'h03);
        check({5'h00, ser_pin_oe_n}, 8'h02);
        rd(4'h5, 8'h00);
        rd(4'h1, 8'hE0);
        check({7'h00, ser_data_in}, 8'h01);
        wr(4'h8, 8'h01);
        settle;
        check({5'h00, ser_pin_oe_n}, 8'h06);
        check({6'h00, ser_clk_in, ser_data_in}, 8'h01);
        wr(4'h8, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h5, 8'hE0);
        check({2'h0, ser_pin_out, ser_pin_oe_n}, 8'h00);
        wr(4'h2, 8'hFF);
        ana_ext <= 8'hFF;
        for (int ch = 0; ch < 4; ch++) begin
            wr(4'h8, {2'h0, 2'(ch), 4'h4});
            settle;
            rd(4'h2, 8'hFF & ~(8'h40 >> ch));
            check({6'h00, adc_channel}, 8'(ch));
        end
        wr(4'h8, 8'h00);
        rd(4'h2, 8'hFF);
        ana_ext <= 8'h00;
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(4'h6, 8'h00);
        wr(4'h6, 8'hFF);
        rd(4'h2, 8'hFF);
        tally_and_finish;
    end
endmodule
`default_nettype wire
